// ### core/acc_sar.sv
`timescale 1ns/1ps
`default_nettype none
module acc_sar
	import acc_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic tick_in,
	input wire logic start_in,
	input wire logic abort_in,
	input wire logic comp_in,
	output logic sample_out,
	output logic [ACC_RES_W-1:0] code_out,
	output logic done_out
);

	typedef struct packed {
		acc_sar_state_t state;
		logic [3:0] cnt;
		logic [3:0] bitpos;
		logic [ACC_RES_W-1:0] code;
		logic done;
	} acc_sar_st_t;

	acc_sar_st_t st_r;
	acc_sar_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		unique case (st_r.state)
			ACC_SAR_IDLE: begin
				if (start_in && !abort_in) begin
					st_nxt.state = ACC_SAR_SAMPLE;
					st_nxt.cnt = ACC_SAMPLE_TICKS - 4'h1;
				end
			end
			ACC_SAR_SAMPLE: begin
				if (tick_in) begin
					if (st_r.cnt == 4'h0) begin
						st_nxt.state = ACC_SAR_CONV;
						st_nxt.bitpos = 4'(ACC_RES_W - 1);
						st_nxt.code = {1'b1, {(ACC_RES_W-1){1'b0}}};
					end else begin
						st_nxt.cnt = st_r.cnt - 4'h1;
					end
				end
			end
			ACC_SAR_CONV: begin
				if (tick_in) begin
					// Keep trial bit only if input at or above DAC level
					if (!comp_in) begin // R02
						st_nxt.code[st_r.bitpos] = 1'b0;
					end
					if (st_r.bitpos == 4'h0) begin
						st_nxt.state = ACC_SAR_IDLE;
						st_nxt.done = 1'b1; // R01
					end else begin
						st_nxt.bitpos = st_r.bitpos - 4'h1;
						st_nxt.code[st_r.bitpos - 4'h1] = 1'b1;
					end
				end
			end
			default: begin
				st_nxt.state = ACC_SAR_IDLE;
			end
		endcase
		if (abort_in) begin
			st_nxt.state = ACC_SAR_IDLE;
			st_nxt.done = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_r <= '{state: ACC_SAR_IDLE, cnt: 4'h0, bitpos: 4'h0, code: '0, done: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sample_out = (st_r.state == ACC_SAR_SAMPLE);
	assign code_out = st_r.code;
	assign done_out = st_r.done;

endmodule : acc_sar
`default_nettype wire

// ### core/acc_top.sv
// How it works
// R01: Each conversion yields a 10-bit value
// R02: Result built by successive approximation
// R03: Two result and two control registers
// R04: Channel field bits 7-4 selects input
// R05: Go bit starts conversion, hardware clears it
// R06: Power bit runs converter, clear shuts off
// R07: Unused control bits read as zero
// R08: Clock field picks Fosc/8, /32, /64, RC
// R09: Format set: right justified, high zeros
// R10: Format clear: left justified, low zeros
// R11: Reference bit picks external pins or rails
// R12: Port config 000x all analog, 111x digital
// R13: Code k makes top k per group digital
// R14: Sleep conversion only with RC clock
// R15: Results load when go bit clears
// R16: Go without power starts nothing
`timescale 1ns/1ps
`default_nettype none
module acc_top
	import acc_pkg::*;
#(
	parameter int unsigned NUM_IN = ACC_NUM_IN
) (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic [ACC_ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [ACC_ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic sleep_in,
	input wire logic rc_tick_in,
	input wire logic comp_in,
	output acc_ana_out_t ana_out,
	output logic irq_out
);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [ACC_NUM_IN-1:0] acc_analog_mask(input logic [2:0] pcfg);
		logic [ACC_NUM_IN-1:0] m;
		m = '0;
		for (int i = 0; i < ACC_NUM_IN; i++) begin
			// Top pcfg pins of each group of eight turn digital
			m[i] = ((i % 8) < (8 - int'(pcfg))); // R13
			// Inputs missing on a smaller variant drop out of the mask; only its reset value shows them as analog
			if (i >= int'(NUM_IN)) begin
				m[i] = 1'b0;
			end
		end
		if (pcfg == ACC_PCFG_ALL_DIG) begin
			m = '0; // R12
		end
		return m;
	endfunction : acc_analog_mask

	function automatic logic [5:0] acc_word(input logic [ACC_ADDR_W-1:0] addr);
		return addr[7:2];
	endfunction : acc_word

	// Same index set decides write response and read response
	function automatic logic acc_mapped(input logic [5:0] idx);
		return idx inside {ACC_IDX_CTRL0, ACC_IDX_CTRL1, ACC_IDX_RES_HI, ACC_IDX_RES_LO,
			ACC_IDX_IRQ_STAT, ACC_IDX_IRQ_CLR, ACC_IDX_IRQ_EN};
	endfunction : acc_mapped

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		acc_ctrl0_t ctrl0;
		acc_ctrl1_t ctrl1;
		logic [7:0] res_hi;
		logic [7:0] res_lo;
		logic [7:0] irq_stat;
		logic [7:0] irq_en;
		logic [5:0] div_cnt;
		logic tick;
		logic aw_held;
		logic [ACC_ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		acc_ana_out_t ana;
		logic irq;
	} acc_st_t;

	acc_st_t st_r;
	acc_st_t st_nxt;

	logic sar_sample;
	logic [ACC_RES_W-1:0] sar_code;
	logic sar_done;
	logic sar_start;
	logic sar_abort;

	// ****************************************
	// Conversion engine
	// ****************************************
	acc_sar u_sar (
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.tick_in(st_r.tick),
		.start_in(sar_start),
		.abort_in(sar_abort),
		.comp_in(comp_in),
		.sample_out(sar_sample),
		.code_out(sar_code),
		.done_out(sar_done)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic [5:0] tc;
		logic do_write;
		logic [5:0] widx;
		logic [7:0] wbyte;
		logic wr_en;
		logic [5:0] ridx;
		logic [7:0] rbyte;
		logic rhit;
		logic [7:0] irq_clr;
		logic [7:0] irq_evt;
		logic [15:0] just;
		acc_ctrl0_t c0w;

		tc = ACC_TC_DIV8;
		do_write = 1'b0;
		widx = '0;
		wbyte = '0;
		wr_en = 1'b0;
		ridx = '0;
		rbyte = '0;
		rhit = 1'b0;
		irq_clr = '0;
		irq_evt = '0;
		just = '0;
		c0w = '0;
		st_nxt = st_r;
		sar_start = 1'b0;
		sar_abort = 1'b0;

		// Conversion clock divider
		unique case (st_r.ctrl1.conversion_clock_select) // R08
			ACC_CLK_DIV8: tc = ACC_TC_DIV8;
			ACC_CLK_DIV32: tc = ACC_TC_DIV32;
			ACC_CLK_DIV64: tc = ACC_TC_DIV64;
			ACC_CLK_RC: tc = ACC_TC_DIV8;
		endcase
		if (st_r.div_cnt >= tc) begin
			st_nxt.div_cnt = '0;
		end else begin
			st_nxt.div_cnt = st_r.div_cnt + 6'h01;
		end
		// Internal RC source keeps running in sleep
		if (st_r.ctrl1.conversion_clock_select == ACC_CLK_RC) begin
			// Comparator sees the trial code a cycle late, so no back-to-back ticks
			st_nxt.tick = rc_tick_in && !st_r.tick; // R08
		end else begin
			// Oscillator stops in sleep, so divided clock freezes
			st_nxt.tick = (st_r.div_cnt >= tc) && !sleep_in; // R14
		end

		// AXI write channels
		// One write in flight: both halves parked until the response is taken
		if (s_axi_awvalid_in && st_r.awready) begin
			st_nxt.aw_held = 1'b1;
			st_nxt.aw_addr = s_axi_awaddr_in;
			st_nxt.awready = 1'b0;
		end
		if (s_axi_wvalid_in && st_r.wready) begin
			st_nxt.w_held = 1'b1;
			st_nxt.w_data = s_axi_wdata_in;
			st_nxt.w_strb = s_axi_wstrb_in;
			st_nxt.wready = 1'b0;
		end
		if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
			do_write = 1'b1;
			widx = acc_word(st_r.aw_addr);
			wbyte = st_r.w_data[7:0];
			wr_en = st_r.w_strb[0];
			st_nxt.aw_held = 1'b0;
			st_nxt.w_held = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = ACC_RESP_OKAY;
			if (!acc_mapped(widx)) begin
				st_nxt.bresp = ACC_RESP_SLVERR;
			end
		end
		if (st_r.bvalid && s_axi_bready_in) begin
			st_nxt.bvalid = 1'b0;
			st_nxt.awready = 1'b1;
			st_nxt.wready = 1'b1;
		end

		// Register writes
		if (do_write && wr_en) begin
			unique case (widx)
				ACC_IDX_CTRL0: begin
					c0w = acc_ctrl0_t'(wbyte);
					st_nxt.ctrl0.channel_select = c0w.channel_select; // R04
					st_nxt.ctrl0.converter_power = c0w.converter_power; // R06
					// Go only accepted with power on; writing zero ignored
					if (c0w.go && c0w.converter_power && !st_r.ctrl0.go) begin // R16
						st_nxt.ctrl0.go = 1'b1; // R05
						sar_start = 1'b1;
					end
				end
				ACC_IDX_CTRL1: begin
					st_nxt.ctrl1 = acc_ctrl1_t'(wbyte & ACC_CTRL1_RMASK); // R07
				end
				ACC_IDX_RES_HI, ACC_IDX_RES_LO, ACC_IDX_IRQ_STAT: begin
					// Read-only: the write is answered but has no effect
				end
				ACC_IDX_IRQ_CLR: begin
					irq_clr = wbyte;
				end
				ACC_IDX_IRQ_EN: begin
					st_nxt.irq_en = wbyte & ACC_IRQ_RMASK;
				end
				default: begin
				end
			endcase
		end

		// Power off kills a running conversion
		if (!st_nxt.ctrl0.converter_power) begin // R06
			st_nxt.ctrl0.go = 1'b0;
			sar_abort = 1'b1;
		end

		// Completion: results and go bit change together
		// Done counts only while go is up, so an aborted run keeps old results
		if (sar_done && st_r.ctrl0.go) begin
			st_nxt.ctrl0.go = 1'b0; // R05
			if (st_r.ctrl1.result_format) begin
				just = {6'h00, sar_code}; // R09
			end else begin
				just = {sar_code, 6'h00}; // R10
			end
			st_nxt.res_hi = just[15:8]; // R15
			st_nxt.res_lo = just[7:0]; // R15
			irq_evt[ACC_IRQ_DONE_BIT] = 1'b1;
		end

		// Sticky status, set beats clear
		st_nxt.irq_stat = ((st_r.irq_stat & ~irq_clr) | irq_evt) & ACC_IRQ_RMASK;
		st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_en);

		// AXI read channel
		if (s_axi_arvalid_in && st_r.arready) begin
			// Data captured at the take and held until rready
			ridx = acc_word(s_axi_araddr_in);
			rhit = acc_mapped(ridx);
			unique case (ridx) // R03
				ACC_IDX_CTRL0: rbyte = st_r.ctrl0 & ACC_CTRL0_RMASK; // R07
				ACC_IDX_CTRL1: rbyte = st_r.ctrl1 & ACC_CTRL1_RMASK; // R07
				ACC_IDX_RES_HI: rbyte = st_r.res_hi;
				ACC_IDX_RES_LO: rbyte = st_r.res_lo;
				ACC_IDX_IRQ_STAT: rbyte = st_r.irq_stat;
				// Clear register is write-only
				ACC_IDX_IRQ_CLR: rbyte = 8'h00;
				ACC_IDX_IRQ_EN: rbyte = st_r.irq_en;
				default: rbyte = 8'h00;
			endcase
			st_nxt.arready = 1'b0;
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = {24'h000000, rbyte};
			st_nxt.rresp = rhit ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
		end
		if (st_r.rvalid && s_axi_rready_in) begin
			st_nxt.rvalid = 1'b0;
			st_nxt.arready = 1'b1;
		end

		// Analog side
		// Pin controls follow the registers on the same edge
		st_nxt.ana.channel_select = st_nxt.ctrl0.channel_select; // R04
		st_nxt.ana.converter_power = st_nxt.ctrl0.converter_power; // R06
		st_nxt.ana.reference_select = st_nxt.ctrl1.reference_select; // R11
		st_nxt.ana.analog_mask = acc_analog_mask(st_nxt.ctrl1.port_config); // R12
		st_nxt.ana.sample = sar_sample;
		st_nxt.ana.dac_code = sar_code;
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_r <= '0;
			st_r.ctrl0 <= acc_ctrl0_t'(ACC_CTRL0_RST);
			st_r.ctrl1 <= acc_ctrl1_t'(ACC_CTRL1_RST);
			st_r.awready <= 1'b1;
			st_r.wready <= 1'b1;
			st_r.arready <= 1'b1;
			// Config zero after reset: every pin analog
			st_r.ana.analog_mask <= {ACC_NUM_IN{1'b1}};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign s_axi_awready_out = st_r.awready;
	assign s_axi_wready_out = st_r.wready;
	assign s_axi_bvalid_out = st_r.bvalid;
	assign s_axi_bresp_out = st_r.bresp;
	assign s_axi_arready_out = st_r.arready;
	assign s_axi_rvalid_out = st_r.rvalid;
	assign s_axi_rdata_out = st_r.rdata;
	assign s_axi_rresp_out = st_r.rresp;
	assign ana_out = st_r.ana;
	assign irq_out = st_r.irq;

endmodule : acc_top
`default_nettype wire

// ### include/acc_pkg.sv
package acc_pkg;

	// ****************************************
	// Register indices and address width
	// ****************************************
	localparam logic [5:0] ACC_IDX_CTRL0 = 6'h14;
	localparam logic [5:0] ACC_IDX_CTRL1 = 6'h15;
	localparam logic [5:0] ACC_IDX_RES_HI = 6'h16;
	localparam logic [5:0] ACC_IDX_RES_LO = 6'h17;
	localparam logic [5:0] ACC_IDX_IRQ_STAT = 6'h18;
	localparam logic [5:0] ACC_IDX_IRQ_CLR = 6'h19;
	localparam logic [5:0] ACC_IDX_IRQ_EN = 6'h1A;
	localparam int unsigned ACC_ADDR_W = 8;

	// ****************************************
	// Field positions, masks and reset values
	// ****************************************
	localparam int unsigned ACC_RES_W = 10;
	localparam int unsigned ACC_NUM_IN = 16;
	localparam logic [7:0] ACC_CTRL0_RST = 8'h00;
	localparam logic [7:0] ACC_CTRL1_RST = 8'h00;
	localparam logic [7:0] ACC_CTRL0_RMASK = 8'hF5;
	localparam logic [7:0] ACC_CTRL1_RMASK = 8'hEF;
	localparam logic [7:0] ACC_IRQ_RMASK = 8'h01;
	localparam int unsigned ACC_IRQ_DONE_BIT = 0;
	localparam logic [1:0] ACC_CLK_DIV8 = 2'h0;
	localparam logic [1:0] ACC_CLK_DIV32 = 2'h1;
	localparam logic [1:0] ACC_CLK_DIV64 = 2'h2;
	localparam logic [1:0] ACC_CLK_RC = 2'h3;
	localparam logic [2:0] ACC_PCFG_ALL_DIG = 3'h7;
	localparam logic [1:0] ACC_RESP_OKAY = 2'h0;
	localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;

	// ****************************************
	// Cycle counts
	// ****************************************
	localparam logic [5:0] ACC_TC_DIV8 = 6'h07;
	localparam logic [5:0] ACC_TC_DIV32 = 6'h1F;
	localparam logic [5:0] ACC_TC_DIV64 = 6'h3F;
	localparam logic [3:0] ACC_SAMPLE_TICKS = 4'h2;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic [3:0] channel_select;
		logic unused3;
		logic go;
		logic unused1;
		logic converter_power;
	} acc_ctrl0_t;

	typedef struct packed {
		logic [1:0] conversion_clock_select;
		logic result_format;
		logic unused4;
		logic [2:0] port_config;
		logic reference_select;
	} acc_ctrl1_t;

	typedef struct packed {
		logic [3:0] channel_select;
		logic converter_power;
		logic reference_select;
		logic [ACC_NUM_IN-1:0] analog_mask;
		logic sample;
		logic [ACC_RES_W-1:0] dac_code;
	} acc_ana_out_t;

	typedef enum logic [1:0] {
		ACC_SAR_IDLE,
		ACC_SAR_SAMPLE,
		ACC_SAR_CONV
	} acc_sar_state_t;

endpackage : acc_pkg

// ### tb/acc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module acc_analog_model
	import acc_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire acc_ana_out_t ana_in,
	input wire logic [ACC_RES_W-1:0] level_in,
	output logic comp_out
);
	logic [ACC_RES_W-1:0] held_r;
	// Hold capacitor tracks only while sampling
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			held_r <= '0;
		else if (ana_in.sample && ana_in.converter_power)
			held_r <= level_in;
	end
	assign comp_out = held_r >= ana_in.dac_code;
endmodule : acc_analog_model
`default_nettype wire

// ### tb/acc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module acc_assertions
	import acc_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [1:0] s_axi_bresp_out,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic [31:0] s_axi_rdata_out,
	input wire acc_ana_out_t ana_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);
	chk_mask_sym: assert property (
		ana_out.analog_mask[15:8] == ana_out.analog_mask[7:0])
		else $error("analog mask groups differ");
	chk_mask_shape: assert property (
		$onehot({1'b0, ana_out.analog_mask[7:0]} + 9'h001) && ana_out.analog_mask[7:0] != 8'h01)
		else $error("analog mask shape wrong");
	chk_power_sample: assert property (!ana_out.converter_power [*2] |-> !ana_out.sample)
		else $error("sampling while powered down");
	chk_bvalid_hold: assert property (
		s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write response dropped");
	chk_rvalid_hold: assert property (
		s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("read response dropped");
	chk_rdata_upper: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h000000)
		else $error("read data upper bits set");
	chk_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |-> ##[1:2] s_axi_rvalid_out)
		else $error("read not answered");
	chk_bresp_code: assert property (
		s_axi_bvalid_out |-> s_axi_bresp_out == ACC_RESP_OKAY || s_axi_bresp_out == ACC_RESP_SLVERR)
		else $error("bad write response code");
endmodule : acc_assertions
bind acc_top acc_assertions u_chk (
	.sys_clk_in(sys_clk_in),
	.nrst_in(nrst_in),
	.s_axi_bvalid_out(s_axi_bvalid_out),
	.s_axi_bready_in(s_axi_bready_in),
	.s_axi_bresp_out(s_axi_bresp_out),
	.s_axi_arvalid_in(s_axi_arvalid_in),
	.s_axi_arready_out(s_axi_arready_out),
	.s_axi_rvalid_out(s_axi_rvalid_out),
	.s_axi_rready_in(s_axi_rready_in),
	.s_axi_rdata_out(s_axi_rdata_out),
	.ana_out(ana_out)
);
`default_nettype wire

// ### tb/acc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module acc_top_test
	import acc_pkg::*;
;
	localparam logic [7:0] C0 = {ACC_IDX_CTRL0, 2'b00};
	localparam logic [7:0] C1 = {ACC_IDX_CTRL1, 2'b00};
	localparam logic [7:0] RH = {ACC_IDX_RES_HI, 2'b00};
	localparam logic [7:0] RL = {ACC_IDX_RES_LO, 2'b00};
	localparam logic [7:0] ST = {ACC_IDX_IRQ_STAT, 2'b00};
	localparam logic [7:0] CL = {ACC_IDX_IRQ_CLR, 2'b00};
	localparam logic [7:0] EN = {ACC_IDX_IRQ_EN, 2'b00};
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic sleep = 1'b0, rc = 1'b0;
	logic [9:0] level = 10'h000;
	logic comp, awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp, wres, r;
	logic [31:0] rdata;
	logic [7:0] d;
	acc_ana_out_t ana;
	int err_total = 0;
	int comparisons = 0;
	int k, lv, ch;
	acc_top dut (
		.sys_clk_in(clk), .nrst_in(nrst),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .sleep_in(sleep),
		.rc_tick_in(rc), .comp_in(comp), .ana_out(ana), .irq_out(irq)
	);
	acc_analog_model u_ana (
		.sys_clk_in(clk), .nrst_in(nrst), .ana_in(ana), .level_in(level), .comp_out(comp)
	);
	initial begin
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		rc <= ($urandom_range(3) == 0);
	end
	task automatic close_out;
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	task automatic tmo;
		err_total++;
		close_out();
	endtask : tmo
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		int n;
		logic aw_t, w_t, b_t;
		b_t = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= ($urandom_range(1) == 0);
		for (n = 0; n < 50 && !b_t; n++) begin
			// Look where everything is settled, act just after the edge
			@(negedge clk);
			aw_t = awvalid && awready;
			w_t = wvalid && wready;
			b_t = bvalid && bready;
			wres = bresp;
			@(posedge clk);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
			if (!bready) bready <= ($urandom_range(1) == 0);
		end
		if (!b_t) tmo();
		bready <= 1'b0;
		@(negedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic [1:0] rs);
		int n;
		logic ar_t, r_t;
		r_t = 1'b0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= ($urandom_range(1) == 0);
		for (n = 0; n < 50 && !r_t; n++) begin
			@(negedge clk);
			ar_t = arvalid && arready;
			r_t = rvalid && rready;
			v = rdata[7:0];
			rs = rresp;
			@(posedge clk);
			if (ar_t) arvalid <= 1'b0;
			if (!rready) rready <= ($urandom_range(1) == 0);
		end
		if (!r_t) tmo();
		rready <= 1'b0;
		@(negedge clk);
	endtask : rd
	task automatic wait_done;
		int n;
		d = 8'h04;
		for (n = 0; n < 400 && d[2] !== 1'b0; n++) rd(C0, d, r);
		if (d[2] !== 1'b0) tmo();
	endtask : wait_done
	initial begin
		void'($urandom(92));
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		rd(C0, d, r); chk("ctrl0 reset", d, 0);
		rd(8'h00, d, r); chk("unmapped read", r, ACC_RESP_SLVERR);
		wr(8'h04, 8'hFF); chk("unmapped write", wres, ACC_RESP_SLVERR);
		for (k = 0; k < 16; k++) begin
			wr(C1, k[7:0]);
			rd(C1, d, r); chk("ctrl1", d, k);
			chk("rresp", r, ACC_RESP_OKAY);
			chk("mask", ana.analog_mask, k < 2 ? 16'hFFFF : k > 13 ? 0 : {2{8'hFF >> k[3:1]}});
			chk("ref", ana.reference_select, k % 2);
		end
		wr(C1, 8'hFF); rd(C1, d, r); chk("ctrl1 unused", d, 8'hEF);
		wr(C0, 8'hFA); rd(C0, d, r); chk("ctrl0 unused", d, 8'hF0);
		chk("channel", ana.channel_select, 4'hF);
		wr(C0, 8'h04); rd(C0, d, r); chk("go unpowered", d, 0);
		wr(EN, 8'h01);
		for (k = 0; k < 8; k++) begin
			lv = $urandom_range(1023);
			ch = $urandom_range(15);
			@(posedge clk);
			level <= lv[9:0];
			sleep <= (k % 4 == 3);
			wr(C1, {k[1:0], k[2], 5'h00});
			wr(C0, {ch[3:0], 4'h5}); chk("channel", ana.channel_select, ch);
			chk("power on", ana.converter_power, 1);
			wait_done();
			rd(RH, d, r); chk("result high", d, k[2] ? lv >> 8 : lv >> 2);
			rd(RL, d, r); chk("result low", d, k[2] ? lv % 256 : lv % 4 * 64);
			rd(ST, d, r); chk("status", d, 1);
			chk("irq on", irq, 1);
			wr(EN, 8'h00); chk("irq masked", irq, 0);
			wr(EN, 8'h01); wr(CL, 8'h01);
			rd(ST, d, r); chk("status cleared", d, 0);
			chk("irq cleared", irq, 0);
		end
		wr(C1, 8'h00); wr(C0, 8'h05);
		repeat (300) @(posedge clk);
		rd(C0, d, r); chk("sleep stall", d, 8'h05);
		wr(C0, 8'h00); rd(C0, d, r); chk("power off abort", d, 0);
		chk("power off", ana.converter_power, 0);
		close_out();
	end
endmodule : acc_top_test
`default_nettype wire
